/* logic/eer_exc_unit.sv */
/*
  Exception entry, late arrival, tail-chaining and return sequencing.
  Assumes the pipeline holds frame_words and the stack pointers stable
  while a sequence runs, and that memory ports hold data valid with ack.
*/
`timescale 1ns/10ps
module eer_exc_unit #(
  parameter int NUM_IRQ = eer_pkg::EER_NUM_IRQ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_IRQ-1:0] peripheral_interrupt_line,
  input wire logic [15:0] sys_pend_set,
  input wire logic prio_we,
  input wire logic [7:0] prio_num,
  input wire logic [2:0] prio_value,
  input wire logic [1:0] sub_bits,
  input wire eer_pkg::eer_mask_t masks,
  input wire logic vto_we,
  input wire logic [31:0] vto_wdata,
  input wire logic stack_align_enable,
  input wire logic core_thread,
  input wire logic core_process,
  input wire logic [31:0] sp_current,
  input wire logic [31:0] main_stack_pointer,
  input wire logic [31:0] process_stack_pointer,
  input wire logic [8*32-1:0] frame_words,
  input wire logic first_exec,
  input wire logic ret_load,
  input wire logic [31:0] ret_value,
  input wire logic stk_ack,
  input wire logic [31:0] stk_rdata,
  input wire logic vec_ack,
  input wire logic [31:0] vec_rdata,
  output eer_pkg::eer_stk_req_t stk,
  output eer_pkg::eer_vec_req_t vec,
  output logic handler_start,
  output logic [31:0] handler_pc,
  output logic [31:0] link_register,
  output logic [31:0] new_sp,
  output logic [7:0] active_exc,
  output logic in_handler,
  output logic ret_bad,
  output eer_pkg::eer_resume_t resume,
  output logic [31:0] vector_table_offset
);

  localparam int NE = eer_pkg::EER_NUM_SYS + NUM_IRQ;
  localparam int IW = $clog2(NE);
  localparam int KW = eer_pkg::EER_KEY_W;
  localparam int PW = eer_pkg::EER_PRIO_W;

  generate
    if (NUM_IRQ < 1 || NUM_IRQ > 240)
    begin : g_bad
      $error("eer_exc_unit: NUM_IRQ must lie in 1..240");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STACK,
    ST_LAUNCH,
    ST_RETCHK,
    ST_UNSTACK
  } eer_st_t;

  typedef struct packed {
    eer_st_t st;
    logic [NE-1:0] pend;
    logic [NE-1:0] act;
    logic [NE*PW-1:0] prio;
    logic [31:0] vto;
    logic [IW-1:0] cur;
    logic [2:0] cnt;
    logic stk_done;
    logic vec_done;
    logic pad;
    logic [31:0] base;
    logic [3:0] rcode;
    eer_pkg::eer_stk_req_t stk;
    eer_pkg::eer_vec_req_t vec;
    logic start;
    logic [31:0] hpc;
    logic [31:0] lr;
    logic [31:0] nsp;
    logic [7:0] aexc;
    logic inh;
    logic rbad;
    eer_pkg::eer_resume_t res;
  } eer_state_t;

  eer_state_t s;
  eer_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // priority keys per exception

  logic [NE*KW-1:0] pkeys;
  logic [KW-1:0] gkey [NE];
  logic [NE-1:0] pend_src;

  generate
    for (genvar e = 0; e < NE; e++)
    begin : g_key
      logic [PW-1:0] p;
      assign p = s.prio[e*PW +: PW];
      if (e == eer_pkg::EER_EXC_NMI)
      begin : g_nmi
        assign pkeys[e*KW +: KW] = eer_pkg::EER_KEY_NMI;
        assign gkey[e] = eer_pkg::EER_KEY_NMI;
      end
      else if (e == eer_pkg::EER_EXC_HARD)
      begin : g_hard
        assign pkeys[e*KW +: KW] = eer_pkg::EER_KEY_HARD;
        assign gkey[e] = eer_pkg::EER_KEY_HARD;
      end
      else
      begin : g_cfg
        // full value orders service; upper field alone decides preemption
        assign pkeys[e*KW +: KW] = eer_pkg::EER_KEY_CFG + {1'b0, p};
        assign gkey[e] = eer_pkg::EER_KEY_CFG + {1'b0, p >> sub_bits};
      end
      if (e < eer_pkg::EER_NUM_SYS)
      begin : g_sys
        assign pend_src[e] = sys_pend_set[e] && eer_pkg::EER_SYS_VALID[e];
      end
      else
      begin : g_irq
        assign pend_src[e] = peripheral_interrupt_line[e-eer_pkg::EER_NUM_SYS];
      end
    end
  endgenerate

  logic pv;
  logic [IW-1:0] pw;
  logic av;
  logic [IW-1:0] aw;

  eer_min_pick #(.N(NE), .KW(KW), .IW(IW)) u_pend_pick (
    .flag(s.pend),
    .keys(pkeys),
    .valid(pv),
    .idx(pw)
  );

  // the most urgent active handler sets the running level
  eer_min_pick #(.N(NE), .KW(KW), .IW(IW)) u_act_pick (
    .flag(s.act),
    .keys(pkeys),
    .valid(av),
    .idx(aw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // eligibility

  logic [KW-1:0] mask_thr;
  logic [KW-1:0] run_grp;
  logic elig;
  logic late;

  always_comb
  begin
    mask_thr = eer_pkg::EER_KEY_THREAD;
    if (masks.base != 3'h0)
      mask_thr = eer_pkg::EER_KEY_CFG + {1'b0, masks.base};
    if (masks.all)
      mask_thr = eer_pkg::EER_KEY_CFG;
    if (masks.fault)
      mask_thr = eer_pkg::EER_KEY_HARD;
    run_grp = av ? gkey[aw] : eer_pkg::EER_KEY_THREAD;
    // strict compare: equal group never preempts and stays pending
    elig = pv && gkey[pw] < run_grp && gkey[pw] < mask_thr;
    late = (s.st == ST_STACK || s.st == ST_LAUNCH) && pv && pw != s.cur
      && gkey[pw] < gkey[s.cur] && gkey[pw] < mask_thr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  logic [31:0] sp_dn;
  logic [31:0] vaddr;
  logic [3:0] entry_code;
  logic ret_ok;

  always_comb
  begin
    sp_dn = sp_current - eer_pkg::EER_FRAME_BYTES;
    vaddr = s.vto + {{(30-IW){1'b0}}, pw, 2'b00};
    entry_code = !core_thread ? eer_pkg::EER_RET_HANDLER_MAIN
      : core_process ? eer_pkg::EER_RET_THREAD_PROC : eer_pkg::EER_RET_THREAD_MAIN;
    ret_ok = ret_value[31:4] == eer_pkg::EER_RET_UPPER
      && (ret_value[3:0] == eer_pkg::EER_RET_HANDLER_MAIN
      || ret_value[3:0] == eer_pkg::EER_RET_THREAD_MAIN
      || ret_value[3:0] == eer_pkg::EER_RET_THREAD_PROC);

    next_s = s;
    next_s.start = 1'b0;
    next_s.rbad = 1'b0;
    next_s.res.valid = 1'b0;
    if (vto_we)
      next_s.vto = vto_wdata & eer_pkg::EER_VTO_MASK;
    if (prio_we && prio_num < 8'(NE))
      next_s.prio[prio_num[IW-1:0]*PW +: PW] = prio_value;

    unique case (s.st)
      ST_IDLE:
      begin
        if (ret_load && s.inh)
        begin
          if (ret_ok)
          begin
            next_s.act[aw] = 1'b0;
            next_s.rcode = ret_value[3:0];
            next_s.st = ST_RETCHK;
          end
          else
            next_s.rbad = 1'b1;
        end
        else if (elig)
        begin
          next_s.cur = pw;
          next_s.cnt = 3'h0;
          next_s.stk_done = 1'b0;
          // pad word keeps the frame on an eight-byte boundary
          next_s.pad = stack_align_enable && sp_dn[2];
          next_s.base = next_s.pad ? sp_dn - eer_pkg::EER_ALIGN_PAD : sp_dn;
          next_s.nsp = next_s.base;
          next_s.lr = {eer_pkg::EER_RET_UPPER, entry_code};
          next_s.vec.req = 1'b1;
          next_s.vec.addr = vaddr;
          next_s.vec_done = 1'b0;
          next_s.st = ST_STACK;
        end
      end
      ST_STACK:
      begin
        if (stk_ack && !s.stk_done)
        begin
          if (s.cnt == 3'h7)
            next_s.stk_done = 1'b1;
          else
            next_s.cnt = s.cnt + 3'h1;
        end
        if (vec_ack && !s.vec_done)
        begin
          // low bit marks the instruction set, not an address bit
          next_s.hpc = {vec_rdata[31:1], 1'b0};
          next_s.vec_done = 1'b1;
          next_s.vec.req = 1'b0;
        end
        if (late)
        begin
          // stacking runs on untouched; only the vector is redone
          next_s.cur = pw;
          next_s.vec_done = 1'b0;
          next_s.vec.req = 1'b1;
          next_s.vec.addr = vaddr;
        end
        else if (next_s.stk_done && next_s.vec_done)
        begin
          next_s.start = 1'b1;
          next_s.pend[s.cur] = 1'b0;
          next_s.act[s.cur] = 1'b1;
          next_s.aexc = 8'(s.cur);
          next_s.st = ST_LAUNCH;
        end
      end
      ST_LAUNCH:
      begin
        if (late)
        begin
          next_s.cur = pw;
          next_s.vec_done = 1'b0;
          next_s.vec.req = 1'b1;
          next_s.vec.addr = vaddr;
          next_s.st = ST_STACK;
        end
        else if (first_exec)
          next_s.st = ST_IDLE;
      end
      ST_RETCHK:
      begin
        if (elig)
        begin
          // frame stays on the stack for the next handler
          next_s.cur = pw;
          next_s.stk_done = 1'b1;
          next_s.vec_done = 1'b0;
          next_s.vec.req = 1'b1;
          next_s.vec.addr = vaddr;
          next_s.lr = {eer_pkg::EER_RET_UPPER, s.rcode};
          next_s.st = ST_STACK;
        end
        else
        begin
          next_s.base = s.rcode == eer_pkg::EER_RET_THREAD_PROC
            ? process_stack_pointer : main_stack_pointer;
          next_s.cnt = 3'h0;
          next_s.st = ST_UNSTACK;
        end
      end
      ST_UNSTACK:
      begin
        if (stk_ack)
        begin
          if (s.cnt == eer_pkg::EER_PC_SLOT)
            next_s.res.pc = stk_rdata;
          if (s.cnt == eer_pkg::EER_PSR_SLOT)
          begin
            next_s.pad = stk_rdata[eer_pkg::EER_PAD_BIT];
            next_s.res.valid = 1'b1;
            next_s.res.sp = s.base + eer_pkg::EER_FRAME_BYTES
              + (next_s.pad ? eer_pkg::EER_ALIGN_PAD : 32'h0000_0000);
            next_s.res.thread = s.rcode != eer_pkg::EER_RET_HANDLER_MAIN;
            next_s.res.process = s.rcode == eer_pkg::EER_RET_THREAD_PROC;
            next_s.st = ST_IDLE;
          end
          else
            next_s.cnt = s.cnt + 3'h1;
        end
      end
    endcase

    // set after clear: a fresh request in a clearing cycle survives
    next_s.pend = next_s.pend | pend_src;
    next_s.inh = |next_s.act;

    // memory port is decoded from the next state, so it registers in step with the sequencer state
    next_s.stk.req = (next_s.st == ST_STACK && !next_s.stk_done) || next_s.st == ST_UNSTACK;
    next_s.stk.we = next_s.st == ST_STACK;
    next_s.stk.addr = next_s.base + {27'h0, next_s.cnt, 2'b00};
    next_s.stk.wdata = frame_words[next_s.cnt*32 +: 32];
    if (next_s.cnt == eer_pkg::EER_PSR_SLOT)
      next_s.stk.wdata[eer_pkg::EER_PAD_BIT] = next_s.pad;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.vto <= eer_pkg::EER_VTO_RESET;
      for (int e = 0; e < NE; e++)
        s.prio[e*PW +: PW] <= eer_pkg::EER_PRIO_RESET;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign stk = s.stk;
  assign vec = s.vec;
  assign handler_start = s.start;
  assign handler_pc = s.hpc;
  assign link_register = s.lr;
  assign new_sp = s.nsp;
  assign active_exc = s.aexc;
  assign in_handler = s.inh;
  assign ret_bad = s.rbad;
  assign resume = s.res;
  assign vector_table_offset = s.vto;

endmodule : eer_exc_unit

/* logic/eer_pkg.sv */
/*
  Shared constants and carrier types for the exception entry/return unit.
  Assumes one 250 MHz clock, synchronous active-low reset, and a pipeline
  and memory system that keep their own side of each handshake.
*/
// What this block does
// - table base is zero after reset, relocatable 0x100 to 0x3FFFFF00
// - lower priority value wins; hard fault and NMI are fixed
// - configurable priorities reset to zero
// - configurable priorities span 0-7, below all fixed ones
// - equal priority: lowest exception number is serviced first
// - only strictly higher priority preempts; equal one stays pending
// - priority splits into upper group and lower subpriority fields
// - preemption decided by group priority alone
// - equal group: order by subpriority, then lowest number
// - pending eligible exception at handler end is tail-chained
// - late arrival keeps stacking, refetches the newer vector
// - enter only if eligible and thread mode or higher priority
// - exceptions not beating the three masks stay pending
// - normal entry pushes an eight-word frame on current stack
// - frame double-word aligned when stack alignment is enabled
// - stack pointer ends at frame bottom; frame keeps return address
// - vector fetched during stacking; handler starts with return code
// - normal entry turns pending to active; late arrival leaves it
// - return starts when handler mode loads a return code into pc
// - return code upper bits 31:4 all ones, low nibble selects
// - codes F1 handler/main, F9 thread/main, FD thread/process
package eer_pkg;

  localparam int EER_NUM_IRQ = 30;
  localparam int EER_NUM_SYS = 16;
  localparam int EER_PRIO_W = 3;
  localparam int EER_KEY_W = 4;
  localparam int EER_FRAME_WORDS = 8;

  // exception numbers with fixed priority
  localparam int EER_EXC_NMI = 2;
  localparam int EER_EXC_HARD = 3;
  // system numbers that exist: 2-6, 11, 12, 14, 15
  localparam logic [15:0] EER_SYS_VALID = 16'hD87C;

  // priority keys: lower wins; fixed ones sit below every configurable one
  localparam logic [3:0] EER_KEY_NMI = 4'h1;
  localparam logic [3:0] EER_KEY_HARD = 4'h2;
  localparam logic [3:0] EER_KEY_CFG = 4'h3;
  localparam logic [3:0] EER_KEY_THREAD = 4'hF;
  localparam logic [2:0] EER_PRIO_RESET = 3'h0;

  localparam logic [31:0] EER_VTO_RESET = 32'h0000_0000;
  localparam logic [31:0] EER_VTO_MASK = 32'h3FFF_FF00;

  localparam logic [31:0] EER_FRAME_BYTES = 32'h0000_0020;
  localparam logic [31:0] EER_ALIGN_PAD = 32'h0000_0004;
  localparam int EER_PAD_BIT = 9;
  localparam logic [2:0] EER_PC_SLOT = 3'h6;
  localparam logic [2:0] EER_PSR_SLOT = 3'h7;

  localparam logic [27:0] EER_RET_UPPER = 28'hFFF_FFFF;
  localparam logic [3:0] EER_RET_HANDLER_MAIN = 4'h1;
  localparam logic [3:0] EER_RET_THREAD_MAIN = 4'h9;
  localparam logic [3:0] EER_RET_THREAD_PROC = 4'hD;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } eer_stk_req_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } eer_vec_req_t;

  typedef struct packed {
    logic all;
    logic fault;
    logic [2:0] base;
  } eer_mask_t;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] sp;
    logic thread;
    logic process;
  } eer_resume_t;

endpackage : eer_pkg

/* logic/eer_min_pick.sv */
/*
  Picks the lowest key among flagged entries; ties go to the lowest index.
  Purely combinational; the caller registers anything it drives out.
*/
`timescale 1ns/10ps
module eer_min_pick #(
  parameter int N = 46,
  parameter int KW = 4,
  parameter int IW = 6
) (
  input wire logic [N-1:0] flag,
  input wire logic [N*KW-1:0] keys,
  output logic valid,
  output logic [IW-1:0] idx
);

  logic [N:0] v_chain;
  logic [KW-1:0] k_chain [N+1];
  logic [IW-1:0] i_chain [N+1];

  assign v_chain[0] = 1'b0;
  assign k_chain[0] = '1;
  assign i_chain[0] = '0;

  ////////////////////////////////////////////////////////////////////////////
  generate
    if (N < 2 || (1 << IW) < N)
    begin : g_bad
      $error("eer_min_pick: index too narrow for entry count");
    end
    for (genvar e = 0; e < N; e++)
    begin : g_ent
      // strict less: an equal key never displaces a lower index
      logic take;
      assign take = flag[e] && (!v_chain[e] || keys[e*KW +: KW] < k_chain[e]);
      assign v_chain[e+1] = v_chain[e] || flag[e];
      assign k_chain[e+1] = take ? keys[e*KW +: KW] : k_chain[e];
      assign i_chain[e+1] = take ? IW'(e) : i_chain[e];
    end
  endgenerate

  assign valid = v_chain[N];
  assign idx = i_chain[N];

endmodule : eer_min_pick

/* sim/eer_exc_checker.sv */
/*
  Port checker for the exception unit, bound onto eer_exc_unit.
  Assumes the single clk domain and synchronous active-low rst_n.
*/
`timescale 1ns/10ps
module eer_exc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire eer_pkg::eer_mask_t masks,
  input wire logic vto_we,
  input wire logic [31:0] vto_wdata,
  input wire logic stack_align_enable,
  input wire logic ret_load,
  input wire logic [31:0] ret_value,
  input wire logic stk_ack,
  input wire eer_pkg::eer_stk_req_t stk,
  input wire eer_pkg::eer_vec_req_t vec,
  input wire logic handler_start,
  input wire logic [31:0] handler_pc,
  input wire logic [31:0] link_register,
  input wire logic in_handler,
  input wire logic ret_bad,
  input wire eer_pkg::eer_resume_t resume,
  input wire logic [31:0] vector_table_offset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_vto;
    vto_we |=> vector_table_offset == ($past(vto_wdata) & eer_pkg::EER_VTO_MASK);
  endproperty
  a_vto: assert property (p_vto) else $error("table base not masked write");
  property p_start;
    handler_start |-> link_register[31:4] == 28'hFFF_FFFF && !handler_pc[0];
  endproperty
  a_start: assert property (p_start) else $error("bad launch values");
  property p_done;
    handler_start |-> !stk.req && !vec.req && in_handler;
  endproperty
  a_done: assert property (p_done) else $error("launch before fetch done");
  property p_hold;
    stk.req && !stk_ack |=> stk.req && $stable(stk.addr) && $stable(stk.we);
  endproperty
  a_hold: assert property (p_hold) else $error("stack request dropped");
  property p_seq;
    stk.req && stk.we && stk_ack |=> !stk.req || stk.addr == $past(stk.addr) + 32'h4;
  endproperty
  a_seq: assert property (p_seq) else $error("frame word order");
  property p_align;
    $rose(stk.req) && stk.we && stack_align_enable |-> stk.addr[2:0] == 3'h0;
  endproperty
  a_align: assert property (p_align) else $error("frame not aligned");
  property p_mask;
    $rose(stk.req) && stk.we && $past(masks.all) |-> vec.addr[7:0] inside {8'h08, 8'h0C};
  endproperty
  a_mask: assert property (p_mask) else $error("masked entry taken");
  property p_unstk;
    $rose(stk.req) && !stk.we |-> $past(ret_load, 2);
  endproperty
  a_unstk: assert property (p_unstk) else $error("unstack without return");
  property p_bad;
    ret_bad |-> $past(ret_load)
      && !($past(ret_value) inside {32'hFFFF_FFF1, 32'hFFFF_FFF9, 32'hFFFF_FFFD});
  endproperty
  a_bad: assert property (p_bad) else $error("good code refused");
  c_entry: cover property (handler_start);
  c_bad: cover property (ret_bad);
  c_resume: cover property (resume.valid);
  c_late: cover property ($changed(vec.addr) && $past(stk.req) && stk.req);
endmodule : eer_exc_checker

bind eer_exc_unit eer_exc_checker eer_exc_checker_inst (.clk, .rst_n, .masks, .vto_we,
  .vto_wdata, .stack_align_enable, .ret_load, .ret_value, .stk_ack, .stk, .vec,
  .handler_start, .handler_pc, .link_register, .in_handler, .ret_bad, .resume,
  .vector_table_offset);

/* sim/eer_mem_model.sv */
/*
  Memory partner: small stack RAM and a vector table.
  Assumes requests stay up until acked; slow adds random stack stalls and counter-paced vector stalls.
*/
`timescale 1ns/10ps
module eer_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire eer_pkg::eer_stk_req_t stk,
  input wire eer_pkg::eer_vec_req_t vec,
  output logic stk_ack,
  output logic [31:0] stk_rdata,
  output logic vec_ack,
  output logic [31:0] vec_rdata
);
  logic [31:0] mem [16];
  logic [31:0] junk = 32'h0;
  logic go = 1'b1;
  always @(posedge clk)
  begin
    // counter, not a negation: zero would stay zero and stall slow vector reads
    junk <= junk + 32'h1;
    go <= !slow || ($urandom_range(1) != 0);
    if (stk.req && stk.we && stk_ack)
      mem[stk.addr[5:2]] <= stk.wdata;
  end
  // idle data lines toggle so a stale read never matches
  assign stk_ack = stk.req && go;
  assign stk_rdata = stk_ack ? mem[stk.addr[5:2]] : junk;
  assign vec_ack = vec.req && (!slow || junk[1]);
  assign vec_rdata = vec_ack ? {vec.addr[27:0], 4'h1} : junk;
endmodule : eer_mem_model

/* sim/exception_entry_return_priority_tb.sv */
/*
  Self-checking bench: entry, priority, masking, tail-chain, return.
  Assumes the checker binds itself and the memory model answers.
*/
`timescale 1ns/10ps
module exception_entry_return_priority_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [29:0] peripheral_interrupt_line = '0;
  logic [15:0] sys_pend_set = '0;
  logic prio_we = 1'b0;
  logic [7:0] prio_num = '0;
  logic [2:0] prio_value = '0;
  logic [1:0] sub_bits = '0;
  eer_pkg::eer_mask_t masks = '0;
  logic vto_we = 1'b0;
  logic [31:0] vto_wdata = '0;
  logic stack_align_enable = 1'b1;
  logic core_thread = 1'b1;
  logic core_process = 1'b0;
  logic [31:0] sp_current = 32'h2000_1004;
  logic [31:0] main_stack_pointer = 32'h2000_0FE0;
  logic [31:0] process_stack_pointer = 32'h2000_0FE0;
  logic [255:0] frame_words;
  logic first_exec = 1'b0;
  logic ret_load = 1'b0;
  logic [31:0] ret_value = '0;
  logic slow = 1'b0;
  logic stk_ack, vec_ack, handler_start, in_handler, ret_bad;
  logic [31:0] stk_rdata, vec_rdata, handler_pc, link_register, new_sp, vector_table_offset;
  logic [7:0] active_exc;
  eer_pkg::eer_stk_req_t stk;
  eer_pkg::eer_vec_req_t vec;
  eer_pkg::eer_resume_t resume;
  logic [73:0] q[$];
  logic [73:0] seen;
  int n_errors = 0;
  int comparisons = 0;
  localparam logic [31:0] ret_hm = 32'hFFFF_FFF1;
  localparam logic [31:0] ret_tm = 32'hFFFF_FFF9;
  localparam logic [31:0] ret_tp = 32'hFFFF_FFFD;
  always #2 clk = ~clk;
  eer_exc_unit eer_exc_unit_inst (.clk, .rst_n, .peripheral_interrupt_line, .sys_pend_set,
    .prio_we, .prio_num, .prio_value, .sub_bits, .masks, .vto_we, .vto_wdata,
    .stack_align_enable, .core_thread, .core_process, .sp_current, .main_stack_pointer,
    .process_stack_pointer, .frame_words, .first_exec, .ret_load, .ret_value, .stk_ack,
    .stk_rdata, .vec_ack, .vec_rdata, .stk, .vec, .handler_start, .handler_pc,
    .link_register, .new_sp, .active_exc, .in_handler, .ret_bad, .resume,
    .vector_table_offset);
  eer_mem_model eer_mem_model_inst (.clk, .slow, .stk, .vec, .stk_ack, .stk_rdata,
    .vec_ack, .vec_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [73:0] got, input logic [73:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one monitor pops the oldest note for every launch, resume or refusal
  always @(posedge clk)
    if (rst_n && (handler_start || resume.valid || ret_bad))
    begin
      seen = {2'h2, 72'h0};
      if (handler_start)
        seen = {2'h0, active_exc, handler_pc, link_register};
      if (resume.valid)
        seen = {2'h1, 6'h0, resume.thread, resume.process, resume.pc, resume.sp};
      chk("event", seen, q.size() > 0 ? q.pop_front() : ~seen);
    end
  task automatic ent(input logic [7:0] n, input logic [31:0] lr);
    logic [31:0] a;
    a = vto_wdata + {22'h0, n, 2'h0};
    q.push_back({2'h0, n, a[27:0], 4'h0, lr});
  endtask : ent
  task automatic res(input logic [1:0] mode);
    q.push_back({2'h1, 6'h0, mode, 32'hA000_0006, 32'h2000_1004});
  endtask : res
  task automatic settle();
    int i;
    for (i = 0; i < 200 && (handler_start | resume.valid | ret_bad) !== 1'b1; i++)
      tick(1);
    if (i == 200)
      chk("wait", 0, 1);
    first_exec = (handler_start === 1'b1);
    tick(1);
    first_exec = 1'b0;
  endtask : settle
  task automatic ret(input logic [31:0] code);
    tick(2);
    ret_load = 1'b1;
    ret_value = code;
    tick(1);
    ret_load = 1'b0;
    settle();
  endtask : ret
  task automatic setp(input logic [7:0] n, input logic [2:0] v);
    prio_we = 1'b1;
    prio_num = n;
    prio_value = v;
    tick(1);
    prio_we = 1'b0;
    // let an edge pass so a following write never re-raises the strobe at once
    tick(1);
  endtask : setp
  task automatic fire(input logic [29:0] lines);
    peripheral_interrupt_line = lines;
    tick(1);
    peripheral_interrupt_line = '0;
  endtask : fire
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 8; i++)
      frame_words[32 * i +: 32] = 32'hA000_0000 + i;
    void'($urandom(32'h866307d3));
    tick(16);
    rst_n = 1'b1;
    tick(1);
    chk("table_base", vector_table_offset, 0);
    vto_wdata = ($urandom & 32'h3FFF_FF00) | 32'h0000_0100;
    vto_we = 1'b1;
    tick(1);
    vto_we = 1'b0;
    tick(1);
    chk("table_base", vector_table_offset, vto_wdata);
    setp(16, 3'h5);
    setp(17, 3'h2);
    ent(17, ret_tm);
    ent(16, ret_tm);
    fire(30'h3);
    settle();
    chk("frame_bottom", new_sp, 32'h2000_0FE0);
    ret(ret_tm);
    res(2'b10);
    ret(ret_tm);
    // default priorities tie, slow memory, process stack
    slow = 1'b1;
    core_process = 1'b1;
    ent(18, ret_tp);
    ent(19, ret_tp);
    fire(30'hC);
    settle();
    ret(ret_tp);
    res(2'b11);
    ret(ret_tp);
    // late arrival: 17 outranks 16 while 16 is still stacking
    ent(17, ret_tp);
    ent(16, ret_tp);
    fire(30'h1);
    tick(1);
    fire(30'h2);
    settle();
    ret(ret_tp);
    res(2'b11);
    ret(ret_tp);
    slow = 1'b0;
    core_process = 1'b0;
    masks.all = 1'b1;
    fire(30'h10);
    tick(20);
    ent(2, ret_tm);
    sys_pend_set = 16'h0004;
    tick(1);
    sys_pend_set = '0;
    settle();
    masks.all = 1'b0;
    ent(20, ret_tm);
    ret(ret_tm);
    q.push_back({2'h2, 72'h0});
    ret(32'hFFFF_FFF5);
    res(2'b10);
    ret(ret_tm);
    // one subpriority bit: 4 and 5 share a group, 2 outranks it
    sub_bits = 2'h1;
    setp(21, 3'h4);
    setp(22, 3'h5);
    setp(23, 3'h2);
    ent(21, ret_tm);
    fire(30'h20);
    settle();
    core_thread = 1'b0;
    fire(30'h40);
    tick(20);
    ent(23, ret_hm);
    fire(30'h80);
    settle();
    res(2'b00);
    ret(ret_hm);
    core_thread = 1'b1;
    ent(22, ret_tm);
    ret(ret_tm);
    res(2'b10);
    ret(ret_tm);
    tick(10);
    chk("notes_left", q.size(), 0);
    tally_and_finish();
  end
  initial
  begin
    #(4 * 20000);
    n_errors++;
    tally_and_finish();
  end
endmodule : exception_entry_return_priority_tb
